// ==== core/ascp_pkg.sv ====
// Package of register map, field layout and reset values for the serial channel
`default_nettype none
package ascp_pkg;
   // ---------------------------------------------------------------
   // Register indices and byte addresses
   // ---------------------------------------------------------------
   localparam logic [7:0] ASCP_CTRL_A_IDX = 8'h01;
   localparam logic [7:0] ASCP_CTRL_A_ADDR = 8'h04;
   localparam logic [7:0] ASCP_CTRL_B_ADDR = 8'h08;
   localparam logic [7:0] ASCP_STATUS_ADDR = 8'h0C;
   localparam logic [7:0] ASCP_TXDATA_ADDR = 8'h10;
   localparam logic [7:0] ASCP_RXDATA_ADDR = 8'h14;
   localparam logic [7:0] ASCP_BAUD_ADDR = 8'h18;
   localparam logic [7:0] ASCP_INTSTAT_ADDR = 8'h1C;
   localparam logic [7:0] ASCP_INTMASK_ADDR = 8'h20;
   // ---------------------------------------------------------------
   // Control register A fields
   // ---------------------------------------------------------------
   localparam int ASCP_A_WAKE = 7;
   localparam int ASCP_A_RXON = 6;
   localparam int ASCP_A_TXON = 5;
   localparam int ASCP_A_PINOFF = 4;
   localparam int ASCP_A_MARKER = 3;
   localparam int ASCP_A_LEN = 2;
   localparam int ASCP_A_PAR = 1;
   localparam int ASCP_A_STOP = 0;
   // ---------------------------------------------------------------
   // Control register B, status and interrupt fields
   // ---------------------------------------------------------------
   localparam int ASCP_B_TXMARK = 7;
   localparam int ASCP_B_MULTI = 6;
   localparam int ASCP_B_SENSE = 4;
   localparam int ASCP_S_OVERRUN_FLAG = 4;
   localparam int ASCP_S_FRAME = 3;
   localparam int ASCP_S_PAR = 2;
   localparam int ASCP_S_RXFULL = 1;
   localparam int ASCP_S_TXEMPTY = 0;
   localparam int ASCP_I_RX = 0;
   localparam int ASCP_I_TX = 1;
   localparam int ASCP_I_ERR = 2;
   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [2:0] ASCP_FMT_RESET = 3'h0;
   localparam logic [15:0] ASCP_BAUD_RESET = 16'h00D9;
   localparam logic [2:0] ASCP_IRQ_RESET = 3'h0;
   localparam logic [3:0] ASCP_CNT_ZERO = 4'h0;
   localparam logic [15:0] ASCP_DIV_ZERO = 16'h0000;

   typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} ascp_tx_e;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} ascp_rx_e;
endpackage : ascp_pkg
`default_nettype wire

// ==== core/ascp_async_serial_port.sv ====
// Asynchronous serial channel with control register A, APB register access
//
// Chosen here: the APB interface to the registers.
`default_nettype none

// Notes on behaviour
// - Length bit picks seven or eight data bits
// - Parity bit adds and checks one parity bit
// - Stop bit picks one or two stop bits
// - Frame: start, data, optional parity, stops
// - Wake filter passes only marked characters
// - Wake filter ignored outside multidrop format
// - Filter off: every character updates flags
// - Receiver off aborts reception, keeps flags
// - Receiver off during halt and reset
// - Transmitter off aborts sending, keeps empty flag
// - Transmitter off during halt and reset
// - Pin-off bit selects DMA end or clock
// - Bit 3 reads last received marker bit in multidrop format, zero otherwise
// - Writing zero to bit 3 clears errors
// - Control fields reset to zero
// - Parity sense: zero even, one odd
// - Multidrop frame carries marker, no parity
module ascp_async_serial_port
   import ascp_pkg::*;
#(
   parameter logic [15:0] BAUD_DIV = ASCP_BAUD_RESET
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial line
   input wire logic rxd,
   output logic txd,
   // Shared clock / DMA end pin
   input wire logic dmaEndTransfer,
   output logic clkPinOut,
   output logic clkPinOeN,
   // System
   input wire logic ioHaltState,
   output logic irq
);
   typedef struct packed {
      logic [31:0] rdata;
      logic ready;
      logic slvErr;
      logic wakeFilterEnable;
      logic receiverOn;
      logic transmitterOn;
      logic ch1ClockPinOff;
      logic rxMarkerBit;
      logic [2:0] fmt;
      logic paritySenseSel;
      logic multidropFormat;
      logic txMarkerBit;
      logic [15:0] baudDiv;
      logic [7:0] txData;
      logic txEmptyFlag;
      logic [7:0] rxData;
      logic rxFullFlag;
      logic overrunFlag;
      logic framingErrorFlag;
      logic parityErrorFlag;
      logic [2:0] irqStat;
      logic [2:0] irqMask;
      logic irqOut;
      logic [15:0] baudCnt;
      logic pinClk;
      logic pinOut;
      logic pinOeN;
      ascp_tx_e txState;
      logic [3:0] txLeft;
      logic [11:0] txShift;
      logic txLine;
      ascp_rx_e rxState;
      logic [15:0] rxCnt;
      logic [3:0] rxIdx;
      logic [3:0] rxTotal;
      logic [10:0] rxShift;
      logic rxMeta;
      logic rxSync;
   } ascp_state_s;

   ascp_state_s cur;
   ascp_state_s next_cur;

   // ---------------------------------------------------------------
   // Frame helpers
   // ---------------------------------------------------------------
   function automatic logic [3:0] ascp_body_bits(input logic [2:0] fmt, input logic multi);
      logic [3:0] n;
      n = fmt[ASCP_A_LEN] ? 4'h8 : 4'h7;
      if (multi || fmt[ASCP_A_PAR]) begin
         n = n + 4'h1;
      end
      return n;
   endfunction : ascp_body_bits

   function automatic logic ascp_parity(input logic [7:0] data, input logic [2:0] fmt,
                                        input logic sense);
      logic p;
      p = fmt[ASCP_A_LEN] ? ^data : ^data[6:0];
      return p ^ sense;
   endfunction : ascp_parity

   logic [7:0] wByte;
   logic [3:0] bodyBits;
   logic baudTick;
   logic apbDone;
   logic rxBit;
   logic [7:0] rxWord;
   logic rxExtra;
   logic rxStopOk;
   logic rxAccept;

   always_comb begin
      next_cur = cur;
      wByte = pwdata[7:0];
      bodyBits = ascp_body_bits(cur.fmt, cur.multidropFormat);
      baudTick = (cur.baudCnt == ASCP_DIV_ZERO);
      apbDone = psel && penable && cur.ready;
      rxBit = cur.rxSync;
      rxWord = cur.fmt[ASCP_A_LEN] ? cur.rxShift[7:0] : {1'b0, cur.rxShift[6:0]};
      rxExtra = cur.fmt[ASCP_A_LEN] ? cur.rxShift[8] : cur.rxShift[7];
      rxStopOk = 1'b1;
      rxAccept = 1'b1;

      // ------------------------------------------------------------
      // Line synchroniser and pin clock
      // ------------------------------------------------------------
      next_cur.rxMeta = rxd;
      next_cur.rxSync = cur.rxMeta;
      // Reload with the divisor itself: a bit lasts divisor plus one cycles, as on receive
      next_cur.baudCnt = baudTick ? cur.baudDiv : cur.baudCnt - 16'h0001;
      if (baudTick) begin
         next_cur.pinClk = ~cur.pinClk;
      end
      next_cur.pinOut = cur.ch1ClockPinOff ? dmaEndTransfer : cur.pinClk;
      next_cur.pinOeN = 1'b0;

      // ------------------------------------------------------------
      // APB slave: one wait state, effects on the completing edge
      // ------------------------------------------------------------
      next_cur.ready = psel && penable && !cur.ready;
      if (psel && penable && !cur.ready) begin
         next_cur.slvErr = 1'b0;
         next_cur.rdata = 32'h0000_0000;
         case (paddr)
            ASCP_CTRL_A_ADDR: begin
               next_cur.rdata[7:0] = {cur.wakeFilterEnable, cur.receiverOn, cur.transmitterOn,
                  cur.ch1ClockPinOff, cur.multidropFormat & cur.rxMarkerBit, cur.fmt};
            end
            ASCP_CTRL_B_ADDR: begin
               next_cur.rdata[ASCP_B_TXMARK] = cur.txMarkerBit;
               next_cur.rdata[ASCP_B_MULTI] = cur.multidropFormat;
               next_cur.rdata[ASCP_B_SENSE] = cur.paritySenseSel;
            end
            ASCP_STATUS_ADDR: begin
               next_cur.rdata[ASCP_S_OVERRUN_FLAG] = cur.overrunFlag;
               next_cur.rdata[ASCP_S_FRAME] = cur.framingErrorFlag;
               next_cur.rdata[ASCP_S_PAR] = cur.parityErrorFlag;
               next_cur.rdata[ASCP_S_RXFULL] = cur.rxFullFlag;
               next_cur.rdata[ASCP_S_TXEMPTY] = cur.txEmptyFlag;
            end
            ASCP_TXDATA_ADDR: next_cur.rdata[7:0] = cur.txData;
            ASCP_RXDATA_ADDR: next_cur.rdata[7:0] = cur.rxData;
            ASCP_BAUD_ADDR: next_cur.rdata[15:0] = cur.baudDiv;
            ASCP_INTSTAT_ADDR: next_cur.rdata[2:0] = cur.irqStat;
            ASCP_INTMASK_ADDR: next_cur.rdata[2:0] = cur.irqMask;
            default: next_cur.slvErr = 1'b1;
         endcase
      end else if (apbDone) begin
         next_cur.rdata = 32'h0000_0000;
         next_cur.slvErr = 1'b0;
      end

      // Clears by software come first so hardware sets below win
      if (apbDone && pwrite) begin
         case (paddr)
            ASCP_CTRL_A_ADDR: begin
               next_cur.wakeFilterEnable = wByte[ASCP_A_WAKE];
               next_cur.receiverOn = wByte[ASCP_A_RXON];
               next_cur.transmitterOn = wByte[ASCP_A_TXON];
               next_cur.ch1ClockPinOff = wByte[ASCP_A_PINOFF];
               next_cur.fmt = wByte[2:0];
               if (!wByte[ASCP_A_MARKER]) begin
                  next_cur.overrunFlag = 1'b0;
                  next_cur.framingErrorFlag = 1'b0;
                  next_cur.parityErrorFlag = 1'b0;
               end
            end
            ASCP_CTRL_B_ADDR: begin
               next_cur.txMarkerBit = wByte[ASCP_B_TXMARK];
               next_cur.multidropFormat = wByte[ASCP_B_MULTI];
               next_cur.paritySenseSel = wByte[ASCP_B_SENSE];
            end
            ASCP_TXDATA_ADDR: begin
               next_cur.txData = wByte;
               next_cur.txEmptyFlag = 1'b0;
            end
            ASCP_BAUD_ADDR: next_cur.baudDiv = pwdata[15:0];
            ASCP_INTSTAT_ADDR: next_cur.irqStat = cur.irqStat & ~pwdata[2:0];
            ASCP_INTMASK_ADDR: next_cur.irqMask = pwdata[2:0];
            default: ;
         endcase
      end
      if (apbDone && !pwrite && paddr == ASCP_RXDATA_ADDR) begin
         next_cur.rxFullFlag = 1'b0;
      end

      // ------------------------------------------------------------
      // Transmitter
      // ------------------------------------------------------------
      case (cur.txState)
         TX_IDLE: begin
            next_cur.txLine = 1'b1;
            if (baudTick && cur.transmitterOn && !cur.txEmptyFlag) begin
               // Start, data LSB first, extra bit, then stops padded with ones
               next_cur.txShift = {4'hF, cur.txData} << 1;
               if (!cur.fmt[ASCP_A_LEN]) begin
                  next_cur.txShift[8] = 1'b1;
               end
               if (cur.multidropFormat) begin
                  next_cur.txShift[bodyBits] = cur.txMarkerBit;
               end else if (cur.fmt[ASCP_A_PAR]) begin
                  next_cur.txShift[bodyBits] = ascp_parity(cur.txData, cur.fmt,
                     cur.paritySenseSel);
               end
               next_cur.txLeft = bodyBits + (cur.fmt[ASCP_A_STOP] ? 4'h3 : 4'h2);
               next_cur.txEmptyFlag = 1'b1;
               next_cur.txState = TX_SHIFT;
            end
         end
         TX_SHIFT: begin
            if (baudTick) begin
               next_cur.txLine = cur.txShift[0];
               next_cur.txShift = {1'b1, cur.txShift[11:1]};
               next_cur.txLeft = cur.txLeft - 4'h1;
               if (cur.txLeft == ASCP_CNT_ZERO) begin
                  next_cur.txLine = 1'b1;
                  next_cur.txState = TX_IDLE;
               end
            end
         end
         default: next_cur.txState = TX_IDLE;
      endcase
      if (!cur.transmitterOn) begin
         next_cur.txState = TX_IDLE;
         next_cur.txLine = 1'b1;
      end

      // ------------------------------------------------------------
      // Receiver: mid-bit sampling on its own bit counter
      // ------------------------------------------------------------
      next_cur.rxCnt = cur.rxCnt - 16'h0001;
      case (cur.rxState)
         RX_IDLE: begin
            if (cur.receiverOn && !rxBit) begin
               next_cur.rxCnt = {1'b0, cur.baudDiv[15:1]};
               next_cur.rxState = RX_START;
            end
         end
         RX_START: begin
            if (cur.rxCnt == ASCP_DIV_ZERO) begin
               next_cur.rxCnt = cur.baudDiv;
               next_cur.rxIdx = ASCP_CNT_ZERO;
               next_cur.rxTotal = bodyBits + (cur.fmt[ASCP_A_STOP] ? 4'h2 : 4'h1);
               next_cur.rxShift = 11'h7FF;
               next_cur.rxState = rxBit ? RX_IDLE : RX_BITS;
            end
         end
         RX_BITS: begin
            if (cur.rxCnt == ASCP_DIV_ZERO) begin
               next_cur.rxCnt = cur.baudDiv;
               next_cur.rxShift[cur.rxIdx] = rxBit;
               next_cur.rxIdx = cur.rxIdx + 4'h1;
               if (cur.rxIdx + 4'h1 == cur.rxTotal) begin
                  next_cur.rxState = RX_IDLE;
                  rxStopOk = rxBit && cur.rxShift[bodyBits];
                  if (cur.multidropFormat) begin
                     next_cur.rxMarkerBit = rxExtra;
                     rxAccept = !cur.wakeFilterEnable || rxExtra;
                  end
                  if (rxAccept) begin
                     // A data read in this same cycle frees the buffer for the new character
                     if (next_cur.rxFullFlag) begin
                        next_cur.overrunFlag = 1'b1;
                     end else begin
                        next_cur.rxData = rxWord;
                        next_cur.rxFullFlag = 1'b1;
                     end
                     if (!rxStopOk) begin
                        next_cur.framingErrorFlag = 1'b1;
                     end
                     if (!cur.multidropFormat && cur.fmt[ASCP_A_PAR] &&
                         rxExtra != ascp_parity(rxWord, cur.fmt, cur.paritySenseSel)) begin
                        next_cur.parityErrorFlag = 1'b1;
                     end
                  end
               end
            end
         end
         default: next_cur.rxState = RX_IDLE;
      endcase
      if (!cur.receiverOn) begin
         next_cur.rxState = RX_IDLE;
      end

      // ------------------------------------------------------------
      // Halt forces both enables off
      // ------------------------------------------------------------
      if (ioHaltState) begin
         next_cur.receiverOn = 1'b0;
         next_cur.transmitterOn = 1'b0;
      end

      // ------------------------------------------------------------
      // Interrupt: sticky events, set beats a same-cycle clear
      // ------------------------------------------------------------
      if (next_cur.rxFullFlag && !cur.rxFullFlag) begin
         next_cur.irqStat[ASCP_I_RX] = 1'b1;
      end
      if (next_cur.txEmptyFlag && !cur.txEmptyFlag) begin
         next_cur.irqStat[ASCP_I_TX] = 1'b1;
      end
      if ((next_cur.overrunFlag && !cur.overrunFlag) ||
          (next_cur.framingErrorFlag && !cur.framingErrorFlag) ||
          (next_cur.parityErrorFlag && !cur.parityErrorFlag)) begin
         next_cur.irqStat[ASCP_I_ERR] = 1'b1;
      end
      next_cur.irqOut = |(next_cur.irqStat & next_cur.irqMask);
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cur <= '0;
         cur.fmt <= ASCP_FMT_RESET;
         cur.baudDiv <= BAUD_DIV;
         cur.baudCnt <= BAUD_DIV;
         cur.txEmptyFlag <= 1'b1;
         cur.txShift <= 12'hFFF;
         cur.txLine <= 1'b1;
         cur.rxShift <= 11'h7FF;
         cur.rxMeta <= 1'b1;
         cur.rxSync <= 1'b1;
         cur.irqMask <= ASCP_IRQ_RESET;
         cur.txState <= TX_IDLE;
         cur.rxState <= RX_IDLE;
      end else begin
         cur <= next_cur;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign prdata = cur.rdata;
   assign pready = cur.ready;
   assign pslverr = cur.slvErr;
   assign txd = cur.txLine;
   assign clkPinOut = cur.pinOut;
   assign clkPinOeN = cur.pinOeN;
   assign irq = cur.irqOut;
endmodule : ascp_async_serial_port
`default_nettype wire

// ==== tb/ascp_asserts.sv ====
// Checker for bus timing, pin sharing and control register A of the serial channel
`default_nettype none
module ascp_asserts
   import ascp_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Register bus
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Pins
   input wire logic txd,
   input wire logic dmaEndTransfer,
   input wire logic clkPinOut,
   input wire logic clkPinOeN,
   input wire logic ioHaltState,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----
   // Shadow of what software wrote, halt clears the enables
   // ----
   logic [7:0] ctlA;
   logic multi;
   logic [2:0] mask;
   logic done;
   logic mapped;
   assign done = psel && penable && pready;
   assign mapped = paddr inside {8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ctlA <= 8'h00;
         multi <= 1'b0;
         mask <= 3'h0;
      end else begin
         if (done && pwrite && paddr == ASCP_CTRL_A_ADDR) begin
            ctlA <= pwdata[7:0] & (ioHaltState ? 8'h9F : 8'hFF);
         end else if (ioHaltState) begin
            ctlA <= ctlA & 8'h9F;
         end
         if (done && pwrite && paddr == ASCP_CTRL_B_ADDR) multi <= pwdata[ASCP_B_MULTI];
         if (done && pwrite && paddr == ASCP_INTMASK_ADDR) mask <= pwdata[2:0];
      end
   end
   // ----
   // Properties
   // ----
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   a_ready_wait: assert property (psel && !penable |-> ##2 pready)
      else $error("pready not on the second edge");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer");
   a_bad_addr: assert property (done && !mapped |-> pslverr && prdata == 32'h0)
      else $error("unmapped address accepted");
   a_ctla_read: assert property (done && !pwrite && paddr == ASCP_CTRL_A_ADDR |->
      prdata == {24'h0, ctlA[7:4], prdata[3], ctlA[2:0]}) else $error("control A readback");
   a_marker_plain: assert property (done && !pwrite && paddr == ASCP_CTRL_A_ADDR && !multi
      |-> !prdata[3]) else $error("marker bit outside multidrop");
   a_pin_dma: assert property (ctlA[4] && $past(ctlA[4]) |->
      clkPinOut == $past(dmaEndTransfer)) else $error("pin not carrying dma end");
   a_pin_driven: assert property (clkPinOeN == 1'b0)
      else $error("shared pin released");
   a_tx_off_idle: assert property (!ctlA[5] [*3] |-> txd)
      else $error("txd active with transmitter off");
   a_irq_masked: assert property (mask == 3'h0 && $past(mask) == 3'h0 |-> !irq)
      else $error("irq with all masked");
   c_write_a: cover property (done && pwrite && paddr == ASCP_CTRL_A_ADDR);
   c_bad_addr: cover property (pslverr);
   c_irq: cover property (irq);
endmodule : ascp_asserts
bind ascp_async_serial_port ascp_asserts i_ascp_asserts (.core_clk, .nrst, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .txd, .dmaEndTransfer, .clkPinOut,
   .clkPinOeN, .ioHaltState, .irq);
`default_nettype wire

// ==== tb/ascp_remote_station.sv ====
// Remote station model for the far end of the serial line
`default_nettype none
module ascp_remote_station #(
   parameter int BT = 9
) (
   // Clock
   input wire logic core_clk,
   // Serial line
   input wire logic txd,
   output logic rxd
);
   timeunit 1ns;
   timeprecision 1ns;
   // Line idles high as if pulled up
   initial rxd = 1'b1;
   task automatic put(input logic b);
      @(posedge core_clk);
      rxd <= b;
      repeat (BT - 1) @(posedge core_clk);
   endtask : put
   // Eight data bits; xb below zero sends no extra bit; sv is the first stop level
   task automatic send(input logic [7:0] d, input int xb, input int ns, input logic sv);
      put(1'b0);
      for (int i = 0; i < 8; i++) put(d[i]);
      if (xb >= 0) put(xb[0]);
      put(sv);
      if (ns > 1) put(1'b1);
      put(1'b1);
   endtask : send
   // Samples mid-bit; bits[0] is the start bit
   task automatic recv(input int n, output logic [31:0] bits);
      int w;
      bits = 32'h0;
      w = 0;
      while (txd !== 1'b0 && w < 4000) begin
         @(posedge core_clk);
         w++;
      end
      repeat (BT / 2) @(posedge core_clk);
      for (int i = 0; i <= n; i++) begin
         bits[i] = txd;
         repeat (BT) @(posedge core_clk);
      end
   endtask : recv
endmodule : ascp_remote_station
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for control register A of the serial channel
`default_nettype none
module tb_top
   import ascp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [15:0] DIV = 16'h0008;
   localparam int BT = 9;
   logic core_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00, d;
   logic [31:0] pwdata = 32'h0, prdata, r, bits, exp;
   logic pready, pslverr, rxd, txd, clkPinOut, clkPinOeN, irq, lastErr;
   logic dmaEndTransfer = 1'b0, ioHaltState = 1'b0;
   int failures = 0, check_count = 0, nb, n;
   ascp_async_serial_port #(.BAUD_DIV(DIV)) i_ascp_async_serial_port (.core_clk, .nrst,
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rxd, .txd,
      .dmaEndTransfer, .clkPinOut, .clkPinOeN, .ioHaltState, .irq);
   ascp_remote_station #(.BT(BT)) i_ascp_remote_station (.core_clk, .txd, .rxd);
   always #20 core_clk = ~core_clk;
   // ----
   // Bus and compare tasks
   // ----
   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      check_count++;
      if (seen !== want) begin
         failures++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, want);
      end
   endtask : chk
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int k;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      k = 0;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      r = prdata;
      lastErr = pslverr;
      chk({31'h0, pready}, 32'h1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      xfer(1'b1, a, wd);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] want);
      xfer(1'b0, a, 32'h0);
      chk(r, want);
   endtask : rdc
   task automatic rxf(input logic [7:0] rd, input int xb, input int ns, input logic sv,
                      input logic [31:0] st);
      i_ascp_remote_station.send(rd, xb, ns, sv);
      rdc(ASCP_STATUS_ADDR, st);
   endtask : rxf
   task automatic tally_and_finish();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (30000) @(posedge core_clk);
      failures++;
      $display("Error at %0t: watchdog expired", $time);
      tally_and_finish();
   end
   // ----
   // Tests
   // ----
   initial begin
      repeat (2) @(posedge core_clk);
      nrst <= 1'b1;
      rdc(ASCP_CTRL_A_ADDR, 32'h0);
      rdc(ASCP_STATUS_ADDR, 32'h1);
      rdc(8'h24, 32'h0);
      chk({31'h0, lastErr}, 32'h1);
      $display("test reset done");
      for (int f = 0; f < 8; f++) begin
         d = 8'h96 ^ 8'(f);
         nb = f[2] ? 8 : 7;
         wr(ASCP_CTRL_B_ADDR, {27'h0, f[0], 4'h0});
         wr(ASCP_CTRL_A_ADDR, 32'h28 | f);
         wr(ASCP_TXDATA_ADDR, {24'h0, d});
         exp = 32'hFFFF_FFFF << (nb + 1);
         for (int i = 0; i < nb; i++) exp[i + 1] = d[i];
         if (f[1]) exp[nb + 1] = (^d[6:0]) ^ (f[2] & d[7]) ^ f[0];
         n = nb + f[1] + f[0] + 1;
         i_ascp_remote_station.recv(n, bits);
         chk(bits, exp & ((32'h1 << (n + 1)) - 32'h1));
      end
      $display("test transmit formats done");
      wr(ASCP_CTRL_B_ADDR, 32'h0);
      wr(ASCP_CTRL_A_ADDR, 32'h47);
      wr(ASCP_INTSTAT_ADDR, 32'h7);
      wr(ASCP_INTMASK_ADDR, 32'h1);
      rxf(8'h5A, 0, 2, 1'b1, 32'h03);
      chk({31'h0, irq}, 32'h1);
      rdc(ASCP_INTSTAT_ADDR, 32'h1);
      wr(ASCP_INTMASK_ADDR, 32'h0);
      repeat (2) @(posedge core_clk);
      chk({31'h0, irq}, 32'h0);
      wr(ASCP_INTSTAT_ADDR, 32'h7);
      rdc(ASCP_INTSTAT_ADDR, 32'h0);
      rdc(ASCP_RXDATA_ADDR, 32'h5A);
      rxf(8'h33, 1, 2, 1'b1, 32'h07);
      rxf(8'h11, 0, 2, 1'b1, 32'h17);
      rdc(ASCP_RXDATA_ADDR, 32'h33);
      wr(ASCP_CTRL_A_ADDR, 32'h47);
      rdc(ASCP_STATUS_ADDR, 32'h01);
      rxf(8'h0F, 0, 2, 1'b0, 32'h0B);
      wr(ASCP_CTRL_A_ADDR, 32'h0F);
      rxf(8'h0F, 0, 2, 1'b1, 32'h0B);
      rdc(ASCP_RXDATA_ADDR, 32'h0F);
      $display("test receive flags done");
      wr(ASCP_CTRL_B_ADDR, 32'h40);
      wr(ASCP_CTRL_A_ADDR, 32'hC4);
      rxf(8'h11, 0, 1, 1'b1, 32'h01);
      rxf(8'h22, 1, 1, 1'b1, 32'h03);
      rdc(ASCP_CTRL_A_ADDR, 32'hCC);
      rdc(ASCP_RXDATA_ADDR, 32'h22);
      wr(ASCP_CTRL_A_ADDR, 32'h44);
      rxf(8'h33, 0, 1, 1'b1, 32'h03);
      rdc(ASCP_CTRL_A_ADDR, 32'h44);
      rdc(ASCP_RXDATA_ADDR, 32'h33);
      wr(ASCP_CTRL_B_ADDR, 32'h0);
      wr(ASCP_CTRL_A_ADDR, 32'hC4);
      rxf(8'h44, -1, 1, 1'b1, 32'h03);
      $display("test multidrop done");
      wr(ASCP_CTRL_A_ADDR, 32'h60);
      ioHaltState <= 1'b1;
      repeat (3) @(posedge core_clk);
      ioHaltState <= 1'b0;
      rdc(ASCP_CTRL_A_ADDR, 32'h0);
      wr(ASCP_CTRL_A_ADDR, 32'h28);
      wr(ASCP_TXDATA_ADDR, 32'h0);
      i_ascp_remote_station.recv(1, bits);
      wr(ASCP_CTRL_A_ADDR, 32'h08);
      repeat (2) @(posedge core_clk);
      chk({31'h0, txd}, 32'h1);
      rdc(ASCP_STATUS_ADDR, 32'h03);
      wr(ASCP_CTRL_A_ADDR, 32'h10);
      dmaEndTransfer <= 1'b1;
      repeat (3) @(posedge core_clk);
      chk({31'h0, clkPinOut}, 32'h1);
      dmaEndTransfer <= 1'b0;
      repeat (3) @(posedge core_clk);
      chk({30'h0, clkPinOut, clkPinOeN}, 32'h0);
      wr(ASCP_CTRL_A_ADDR, 32'h08);
      repeat (2) @(posedge core_clk);
      r[0] = clkPinOut;
      repeat (BT) @(posedge core_clk);
      chk({31'h0, r[0] ^ clkPinOut}, 32'h1);
      $display("test halt and pin done");
      tally_and_finish();
   end
endmodule : tb_top
`default_nettype wire
